// >>> pkg/umspi_pkg.sv
/*
 * Shared constants and types for the USART master SPI block.
 * Assumes a single 125 MHz system clock and active-low asynchronous reset.
 */
package umspi_pkg;

	// Operating mode select encoding
	localparam logic [1:0] UMSPI_MODE_SPI = 2'h3;

	// Frame layout
	localparam int UMSPI_DATA_W = 8;
	localparam logic [3:0] UMSPI_HALF_LAST = 4'hF;
	localparam logic [3:0] UMSPI_HALF_FIRST = 4'h0;
	localparam logic [2:0] UMSPI_BIT_FIRST = 3'h0;
	localparam logic [2:0] UMSPI_BIT_ONE = 3'h1;

	// Baud divisor
	localparam int UMSPI_DIV_W = 12;
	localparam logic [11:0] UMSPI_DIV_RESET = 12'h000;
	localparam logic [11:0] UMSPI_DIV_ONE = 12'h001;

	// Transmit queue and receive buffer
	localparam int UMSPI_FIFO_DEPTH = 16;
	localparam logic [1:0] UMSPI_RX_DEPTH = 2'h2;
	localparam logic [1:0] UMSPI_RX_EMPTY = 2'h0;

	// Reset and idle levels
	localparam logic UMSPI_LINE_IDLE = 1'h1;
	localparam logic [7:0] UMSPI_BYTE_RESET = 8'h00;

	typedef enum logic {UMSPI_ST_IDLE, UMSPI_ST_SHIFT} umspi_state_type;

endpackage

// >>> verilog/umspi_fifo.sv
/*
 * Transmit queue: synchronous FIFO with registered head data.
 * Assumes one clock; ce freezes all state while low.
 */
module umspi_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW-1:0] rd_d;
	logic push;
	logic pop;

	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_ready && out_valid;
	assign rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Head is re-read every cycle; a write to the head slot bypasses the memory
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			out_data <= '0;
		else if (ce)
			out_data <= (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else if (ce)
		begin
			if (push)
				wr_q <= AW'(wr_q + 1'b1);
			rd_q <= rd_d;
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end

endmodule // umspi_fifo

// >>> verilog/umspi_baud.sv
/*
 * Half-bit tick generator: one tick every divisor+1 clocks.
 * Assumes run comes from logic on the same clock.
 */
module umspi_baud
	import umspi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Control
	input wire logic run,
	input wire logic [UMSPI_DIV_W-1:0] divisor,
	// Tick
	output logic tick
);
	logic [UMSPI_DIV_W-1:0] cnt_q;

	// Counter parks at zero while stopped, so the first tick comes at once
	assign tick = run && cnt_q == UMSPI_DIV_RESET;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= UMSPI_DIV_RESET;
		else if (ce)
		begin
			if (!run)
				cnt_q <= UMSPI_DIV_RESET;
			else if (tick)
				cnt_q <= divisor;
			else
				cnt_q <= cnt_q - UMSPI_DIV_ONE;
		end
	end

endmodule // umspi_baud

// >>> verilog/umspi_top.sv
/*
 * USART in master SPI mode: baud generation, four clock modes, 8-bit frames,
 * queued transmit, two-entry receive buffer.
 * Assumes configuration inputs come from logic on clk; only serial_in_pin
 * is asynchronous. Pin muxing is done outside using the enables.
 */
module umspi_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Configuration
	input wire logic [1:0] op_mode_select,
	input wire logic clk_polarity_bit,
	input wire logic clk_phase_bit,
	input wire logic data_order_bit,
	input wire logic tx_enable_bit,
	input wire logic rx_enable_bit,
	input wire logic [umspi_pkg::UMSPI_DIV_W-1:0] baud_divisor,
	input wire logic baud_divisor_wr,
	// Transmit data
	input wire logic [umspi_pkg::UMSPI_DATA_W-1:0] tx_data,
	input wire logic tx_write,
	output logic tx_ready,
	// Receive data
	output logic [umspi_pkg::UMSPI_DATA_W-1:0] rx_data,
	input wire logic rx_read,
	// Status
	output logic rx_complete_flag,
	output logic tx_complete_flag,
	input wire logic tx_complete_clr,
	output logic tx_buffer_empty_flag,
	output logic frame_error_flag,
	output logic overrun_flag,
	output logic parity_error_flag,
	// Pins
	output logic xfer_clk_pin,
	output logic xfer_clk_pin_oe,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic serial_in_pin,
	output logic serial_in_en
);
	import umspi_pkg::*;

	function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] idx, input logic lsb_first);
		pick_bit = lsb_first ? b[idx] : b[3'h7 - idx];
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic din, input logic lsb_first);
		shift_in = lsb_first ? {din, b[7:1]} : {b[6:0], din};
	endfunction

	logic in_meta_q;
	logic in_sync_q;
	logic [UMSPI_DIV_W-1:0] baud_q;
	logic tx_en_q;
	umspi_state_type state_q;
	logic [3:0] hcnt_q;
	logic sck_q;
	logic [7:0] tx_sh_q;
	logic [7:0] rx_sh_q;
	logic mosi_q;
	logic [7:0] rx_q [2];
	logic [1:0] rx_cnt_q;
	logic tx_cmp_q;

	logic spi_active;
	logic tick;
	logic f_valid;
	logic [7:0] f_data;
	logic start_ok;
	logic shifting;
	logic last;
	logic load;
	logic sample_edge;
	logic [2:0] setup_idx;
	logic [7:0] frame_rx;
	logic rx_store;
	logic rx_push;
	logic rx_pop;
	logic [1:0] rx_slot;

	assign spi_active = op_mode_select == UMSPI_MODE_SPI;

	// Serial input crosses from the pin domain
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_meta_q <= UMSPI_LINE_IDLE;
			in_sync_q <= UMSPI_LINE_IDLE;
		end
		else if (ce)
		begin
			in_meta_q <= serial_in_pin;
			in_sync_q <= in_meta_q;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			baud_q <= UMSPI_DIV_RESET;
		else if (ce && baud_divisor_wr)
			baud_q <= baud_divisor;
	end

	// Disabling only lands once the shifter and queue are drained
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tx_en_q <= 1'b0;
		else if (ce)
		begin
			if (tx_enable_bit)
				tx_en_q <= 1'b1;
			else if (state_q == UMSPI_ST_IDLE && !f_valid)
				tx_en_q <= 1'b0;
		end
	end

	umspi_baud u_baud
	(
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.run(spi_active && tx_en_q),
		.divisor(baud_q),
		.tick(tick)
	);

	umspi_fifo #(.WIDTH(UMSPI_DATA_W), .DEPTH(UMSPI_FIFO_DEPTH)) u_txq
	(
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.in_data(tx_data),
		.in_valid(tx_write),
		.in_ready(tx_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(load)
	);

	assign shifting = state_q == UMSPI_ST_SHIFT;
	assign last = shifting && hcnt_q == UMSPI_HALF_LAST;
	assign start_ok = spi_active && tx_en_q && f_valid;
	// Next byte is taken on the closing edge, so frames abut
	assign load = tick && start_ok && (!shifting || last);
	// Even half-steps are leading edges; phase moves sampling to trailing
	assign sample_edge = hcnt_q[0] == clk_phase_bit;
	assign setup_idx = clk_phase_bit ? hcnt_q[3:1] : 3'(hcnt_q[3:1] + UMSPI_BIT_ONE);
	assign frame_rx = sample_edge ? shift_in(rx_sh_q, in_sync_q, data_order_bit) : rx_sh_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_q <= UMSPI_ST_IDLE;
		else if (ce)
		begin
			case (state_q)
				UMSPI_ST_IDLE:
					if (load)
						state_q <= UMSPI_ST_SHIFT;
				UMSPI_ST_SHIFT:
					if (!spi_active || (tick && last && !load))
						state_q <= UMSPI_ST_IDLE;
				default:
					state_q <= UMSPI_ST_IDLE;
			endcase
		end
	end

	// Sixteen half-steps per frame; the clock toggles on each one
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hcnt_q <= UMSPI_HALF_FIRST;
			sck_q <= 1'b0;
		end
		else if (ce)
		begin
			if (load || !spi_active)
			begin
				hcnt_q <= UMSPI_HALF_FIRST;
				sck_q <= 1'b0;
			end
			else if (tick && shifting)
			begin
				hcnt_q <= 4'(hcnt_q + 1'b1);
				sck_q <= ~sck_q;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tx_sh_q <= UMSPI_BYTE_RESET;
		else if (ce && load)
			tx_sh_q <= f_data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			mosi_q <= UMSPI_LINE_IDLE;
		else if (ce)
		begin
			if (load)
			begin
				// Phase 0 must present the first bit before the first edge
				if (!clk_phase_bit)
					mosi_q <= pick_bit(f_data, UMSPI_BIT_FIRST, data_order_bit);
			end
			else if (!spi_active || (tick && last))
				mosi_q <= UMSPI_LINE_IDLE;
			else if (tick && shifting && !sample_edge)
				mosi_q <= pick_bit(tx_sh_q, setup_idx, data_order_bit);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rx_sh_q <= UMSPI_BYTE_RESET;
		else if (ce && tick && shifting && sample_edge)
			rx_sh_q <= shift_in(rx_sh_q, in_sync_q, data_order_bit);
	end

	// Receive buffer: a full buffer refuses the new byte, older data stay
	assign rx_store = tick && last && rx_enable_bit;
	assign rx_pop = rx_read && rx_cnt_q != UMSPI_RX_EMPTY;
	assign rx_push = rx_store && rx_cnt_q != UMSPI_RX_DEPTH;
	assign rx_slot = 2'(rx_cnt_q - rx_pop);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_q[0] <= UMSPI_BYTE_RESET;
			rx_q[1] <= UMSPI_BYTE_RESET;
			rx_cnt_q <= UMSPI_RX_EMPTY;
		end
		else if (ce)
		begin
			if (!rx_enable_bit)
				rx_cnt_q <= UMSPI_RX_EMPTY;
			else
			begin
				if (rx_pop)
					rx_q[0] <= rx_q[1];
				if (rx_push)
					rx_q[rx_slot[0]] <= frame_rx;
				rx_cnt_q <= 2'(rx_cnt_q + rx_push - rx_pop);
			end
		end
	end

	// A completion in the clearing cycle is kept
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tx_cmp_q <= 1'b0;
		else if (ce)
		begin
			if (tick && last && !start_ok)
				tx_cmp_q <= 1'b1;
			else if (tx_complete_clr)
				tx_cmp_q <= 1'b0;
		end
	end

	assign rx_data = rx_q[0];
	assign rx_complete_flag = rx_cnt_q != UMSPI_RX_EMPTY;
	assign tx_complete_flag = tx_cmp_q;
	assign tx_buffer_empty_flag = !f_valid;
	assign frame_error_flag = 1'b0;
	assign overrun_flag = 1'b0;
	assign parity_error_flag = 1'b0;

	assign xfer_clk_pin = clk_polarity_bit ^ sck_q;
	assign xfer_clk_pin_oe = spi_active && tx_en_q;
	assign serial_out_pin = mosi_q;
	assign serial_out_oe = spi_active && tx_en_q;
	assign serial_in_en = spi_active && rx_enable_bit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_idle_clk_level: assert property (!shifting |-> xfer_clk_pin == clk_polarity_bit)
		else $error("idle transfer clock not at polarity level");
	chk_idle_line_high: assert property (!shifting |-> serial_out_pin == UMSPI_LINE_IDLE)
		else $error("serial output not high while idle");
	chk_error_flags_zero: assert property (!(frame_error_flag || overrun_flag || parity_error_flag))
		else $error("error flag set in spi mode");
	chk_start_needs_mode: assert property ($rose(shifting) |-> $past(spi_active && tx_en_q && f_valid))
		else $error("frame started without mode, enable or data");
	chk_clk_edge_tick: assert property (shifting && $past(shifting) && $changed(sck_q) |-> $past(tick && ce))
		else $error("transfer clock moved without baud tick");
	chk_rx_overflow_keep: assert property (ce && rx_enable_bit && rx_store && rx_cnt_q == UMSPI_RX_DEPTH && !rx_read
		|=> rx_cnt_q == UMSPI_RX_DEPTH && rx_data == $past(rx_data))
		else $error("overflow disturbed buffered data");
	chk_tx_disable_defer: assert property (ce && !tx_enable_bit && tx_en_q && (shifting || f_valid) |=> tx_en_q)
		else $error("transmitter disabled with data pending");
	chk_back_to_back: assert property (ce && tick && last && start_ok |=> shifting && hcnt_q == UMSPI_HALF_FIRST)
		else $error("pending byte did not follow directly");
	chk_cmp_set_wins: assert property (ce && tick && last && !start_ok |=> tx_complete_flag)
		else $error("transmit complete lost at frame end");
	chk_mosi_setup_edge: assert property (shifting && $past(shifting) && $changed(serial_out_pin)
		|-> $past(tick && ce && !sample_edge))
		else $error("serial output moved on a sampling edge");
	chk_load_takes_head: assert property (ce && load |=> tx_sh_q == $past(f_data))
		else $error("shift register did not take queued byte");
	chk_rx_flush_off: assert property (ce && !rx_enable_bit |=> !rx_complete_flag)
		else $error("receive buffer kept data while receiver off");

endmodule // umspi_top

// >>> tb/umspi_slave_model.sv
/*
 * Behavioural SPI slave facing the master: samples the data out line, answers on the data in line.
 * Assumes the bench pulses srst while the transfer clock rests, after any mode change.
 */
module umspi_slave_model
(
	// Serial lines
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// Mode and control
	input wire logic cpha,
	input wire logic lsb_first,
	input wire logic srst,
	// Observed traffic
	output logic [7:0] rx_byte,
	output int rx_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	int edges;
	int idx;
	logic [7:0] sh;
	logic [7:0] resp;
	logic mosi_lag;
	// Lagged copy gives the value held just before the sampling edge
	assign #0.5 mosi_lag = mosi;
	assign resp = 8'h5A + 8'(rx_cnt);
	assign idx = cpha ? ((edges == 0) ? 0 : (edges - 1) / 2) : edges / 2;
	// With phase 1, before the first setup edge the line carries no valid bit
	assign miso = (cpha && edges == 0) ? ~resp[lsb_first ? 0 : 7] : resp[lsb_first ? idx : 7 - idx];
	always @(sclk or posedge srst)
	begin
		if (srst)
		begin
			edges = 0;
			rx_cnt = 0;
		end
		else
		begin
			edges = edges + 1;
			if ((edges % 2) == (cpha ? 0 : 1))
				sh = lsb_first ? {mosi_lag, sh[7:1]} : {sh[6:0], mosi_lag};
			if (edges == 16)
			begin
				rx_byte = sh;
				rx_cnt = rx_cnt + 1;
				edges = 0;
			end
		end
	end
endmodule // umspi_slave_model

// >>> tb/umspi_top_tb_top.sv
/*
 * Self-checking bench for the master SPI block with a slave model on the serial side.
 * Assumes a 125 MHz clock; inputs change 1 ns after each rising edge.
 */
module umspi_top_tb_top
	import umspi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, nrst, ce, cpol, cpha, lsb, txen, rxen, div_wr, tx_write, tx_ready, rx_read;
	logic rxc, txc, txc_clr, tbe, fe, ov, pe, sck, sck_oe, mosi, mosi_oe, miso, rx_en_o, srst, sck_prev;
	logic [1:0] mode;
	logic [11:0] div;
	logic [7:0] tx_data, rx_data, s_byte, b;
	logic [7:0] q[$];
	int s_cnt, err_total, n_tests, seed, tog, t_first, t_last, cyc, k;
	umspi_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .op_mode_select(mode), .clk_polarity_bit(cpol),
		.clk_phase_bit(cpha), .data_order_bit(lsb), .tx_enable_bit(txen), .rx_enable_bit(rxen),
		.baud_divisor(div), .baud_divisor_wr(div_wr), .tx_data(tx_data), .tx_write(tx_write),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_read(rx_read), .rx_complete_flag(rxc),
		.tx_complete_flag(txc), .tx_complete_clr(txc_clr), .tx_buffer_empty_flag(tbe),
		.frame_error_flag(fe), .overrun_flag(ov), .parity_error_flag(pe), .xfer_clk_pin(sck),
		.xfer_clk_pin_oe(sck_oe), .serial_out_pin(mosi), .serial_out_oe(mosi_oe),
		.serial_in_pin(miso), .serial_in_en(rx_en_o));
	umspi_slave_model slave_u (.sclk(sck), .mosi(mosi), .miso(miso), .cpha(cpha), .lsb_first(lsb),
		.srst(srst), .rx_byte(s_byte), .rx_cnt(s_cnt));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Toggle counter and timing of the transfer clock
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sck_prev <= sck;
		if (sck !== sck_prev)
		begin
			tog <= tog + 1;
			if (tog == 0)
				t_first <= cyc;
			t_last <= cyc;
		end
	end
	always @(s_cnt)
		if (s_cnt > 0)
			check(s_byte, q.pop_front());
	function automatic logic [7:0] resp_of(input int n);
		return 8'h5A + 8'(n);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse_srst_clr;
		srst = 1'b1;
		txc_clr = 1'b1;
		tick(1);
		srst = 1'b0;
		txc_clr = 1'b0;
		tog = 0;
		tick(1);
	endtask
	// Back to back writes; a write while full is dropped, so it is not expected
	task automatic send(input int n);
		for (int i = 0; i < n; i++)
		begin
			b = 8'($random(seed));
			if (tx_ready === 1'b1)
				q.push_back(b);
			tx_data = b;
			tx_write = 1'b1;
			tick(1);
		end
		tx_write = 1'b0;
	endtask
	task automatic wait_txc;
		k = 0;
		while (txc !== 1'b1 && k < 5000)
		begin
			tick(1);
			k++;
		end
		check(txc, 1'b1);
		// Toggle monitor sees the closing clock edge one cycle late
		tick(1);
	endtask
	task automatic pop(input logic [7:0] exp);
		check(rx_data, exp);
		rx_read = 1'b1;
		tick(1);
		rx_read = 1'b0;
		tick(1);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_total++;
		test_done;
	end
	initial
	begin
		seed = 32'h229040b7;
		{nrst, cpol, cpha, lsb, txen, rxen, div_wr, tx_write, rx_read, txc_clr, cyc, tog} = '0;
		{ce, srst, sck_prev} = 3'h7;
		{mode, div, tx_data} = '0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		tick(1);
		check({tx_ready, tbe, rxc, txc, fe, ov, pe, mosi, sck}, 9'h182);
		mode = UMSPI_MODE_SPI;
		txen = 1'b1;
		tick(1);
		check({sck_oe, mosi_oe, rx_en_o}, 3'h6);
		pulse_srst_clr;
		send(1);
		wait_txc;
		check(tog, 16);
		check(t_last - t_first, 15);
		for (int m = 0; m < 8; m++)
		begin
			{lsb, cpha, cpol} = 3'(m);
			div = 12'(2 + {$random(seed)} % 4);
			div_wr = 1'b1;
			rxen = 1'b1;
			tick(1);
			div_wr = 1'b0;
			pulse_srst_clr;
			check({txc, sck}, {1'b0, cpol});
			send(2);
			k = 0;
			while (s_cnt < 1 && k < 2000)
			begin
				tick(1);
				k++;
			end
			check(s_cnt, 1);
			check(txc, 1'b0);
			wait_txc;
			check(tog, 32);
			check(t_last - t_first, 31 * (div + 1));
			check({mosi, sck}, {1'b1, cpol});
			pop(resp_of(0));
			pop(resp_of(1));
		end
		pulse_srst_clr;
		send(3);
		wait_txc;
		pop(resp_of(0));
		pop(resp_of(1));
		check(rxc, 1'b0);
		mode = 2'h0;
		tick(1);
		send(17);
		check({tx_ready, tbe}, 2'h0);
		txen = 1'b0;
		rxen = 1'b0;
		tick(4);
		check({sck_oe, mosi_oe, rxc}, 3'h0);
		mode = UMSPI_MODE_SPI;
		pulse_srst_clr;
		check({sck_oe, mosi_oe}, 2'h3);
		// A frozen enable must hold the clock and data lines mid-frame
		b = {6'h0, sck, mosi};
		ce = 1'b0;
		tick(5);
		check({sck, mosi}, b[1:0]);
		ce = 1'b1;
		wait_txc;
		check({s_cnt[7:0], tbe, tx_ready}, {8'd16, 2'h3});
		tick(2);
		check(sck_oe, 1'b0);
		test_done;
	end
endmodule // umspi_top_tb_top
